// >>> inc/frs_pkg.sv
/*
  Constants, register map and mode type of the frequency reference select block.
  Assumes a single 100 MHz clock and an AHB-Lite master on the register side.
*/
// What this block does
// - Units digit picks ten or five volt span
// - Tens digit adds offset zero span
// - Programmable analog low-pass, larger is slower
// - High and low end frequencies, 0.1 Hz
// - Bias bit zero forward, one reverse
// - Negative part reverses only when enabled
// - External reverse terminal inverts curve direction
// - Below zero crossing is invalid when disabled
// - Up/down value kept over stop if set
// - Step unit 0.01 Hz or 0.1 Hz
// - Step is unit times multiplier 1..250
// - Segment mode 0..5, default external four
// - Modes 4 and 5 run automatically
// - Sixteen speeds: main plus fifteen segments
// - Ramp selection from two half registers
// - Each segment runs its timer; zero skips
// - Segment direction from two half registers
// - Internal mode ignores external reverse terminal
// - Four-segment mode uses high/medium/low terminals
package frs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CHANNEL = 8'h00;
  localparam logic [7:0] OFS_FILTER = 8'h04;
  localparam logic [7:0] OFS_HIGH_FREQ = 8'h08;
  localparam logic [7:0] OFS_LOW_FREQ = 8'h0c;
  localparam logic [7:0] OFS_BIAS = 8'h10;
  localparam logic [7:0] OFS_UPDOWN = 8'h14;
  localparam logic [7:0] OFS_SEG_MODE = 8'h18;
  localparam logic [7:0] OFS_SEG_DIR = 8'h1c;
  localparam logic [7:0] OFS_SEG_RAMP = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_UD_VALUE = 8'h28;
  localparam logic [7:0] OFS_SEG_FREQ = 8'h40;
  localparam logic [7:0] OFS_SEG_TIME = 8'h80;
  // Field positions
  localparam int BIAS_HIGH_BIT = 0;
  localparam int BIAS_LOW_BIT = 1;
  localparam int BIAS_NEGREV_BIT = 2;
  localparam int BIAS_CHAN2_BIT = 3;
  localparam int UD_MEM_BIT = 0;
  localparam int UD_UNIT_BIT = 1;
  localparam int UD_MULT_LSB = 8;
  localparam int ST_DIR_BIT = 20;
  localparam int ST_RUN_BIT = 21;
  localparam int ST_SEG_LSB = 24;
  // Reset values
  localparam logic [3:0] RST_CHANNEL = 4'h0;
  localparam logic [9:0] RST_FILTER = 10'h014;
  localparam logic [13:0] RST_HIGH_FREQ = 14'h01f4;
  localparam logic [13:0] RST_LOW_FREQ = 14'h0000;
  localparam logic [7:0] RST_MULT = 8'h01;
  localparam logic [2:0] RST_SEG_MODE = 3'h2;
  // Limits and scaling
  localparam logic [13:0] MAX_FREQ_D1 = 14'h2710;
  localparam logic [16:0] MAX_FREQ_D2 = 17'h186a0;
  localparam logic [11:0] FULL_10V = 12'hfff;
  localparam logic [11:0] FULL_5V = 12'h7ff;
  localparam logic [11:0] ZERO_10V = 12'h333;
  localparam logic [11:0] ZERO_5V = 12'h199;
  localparam logic [13:0] RECIP_10V = 14'h1001;
  localparam logic [13:0] RECIP_5V = 14'h2004;
  localparam logic [13:0] RECIP_LZ_10V = 14'h1401;
  localparam logic [13:0] RECIP_LZ_5V = 14'h2803;
  localparam logic [12:0] T_FULL = 13'h1000;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] MS_PER_SEC = 10'h3e8;
  typedef enum logic [2:0] {
    FRS_NORMAL, FRS_INT16, FRS_EXT4, FRS_EXT16, FRS_EXT4_AUTO, FRS_EXT16_AUTO
  } frs_mode_type;
endpackage

// >>> design/frs_lowpass.sv
/*
  First-order low-pass for the selected analog sample, stepped once per millisecond.
  Assumes sample is already synchronised and tick is a one-cycle pulse.
*/
`timescale 1ns/100ps
module frs_lowpass #(
  parameter int WIDTH = 12,
  parameter int FRAC = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic [9:0] time_ms,
  // Data
  input wire logic [WIDTH-1:0] sample,
  output logic [WIDTH-1:0] filtered
);
  logic [WIDTH+FRAC-1:0] acc_q;
  logic [WIDTH+FRAC-1:0] target;
  logic [3:0] shift;
  logic signed [WIDTH+FRAC:0] diff;
  // Shift by the bit length of the time: roughly a time constant in ms
  always_comb
  begin
    shift = 4'h0;
    for (int i = 0; i < 10; i++)
    begin
      if (time_ms[i])
        shift = 4'(i + 1);
    end
    target = {sample, {FRAC{1'b0}}};
    diff = $signed({1'b0, target}) - $signed({1'b0, acc_q});
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_q <= '0;
    else if (tick)
      acc_q <= (WIDTH+FRAC)'($signed({1'b0, acc_q}) + (diff >>> shift));
  end
  assign filtered = acc_q[WIDTH+FRAC-1:FRAC];
  a_filter_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && time_ms == 10'h000 |=> filtered == $past(sample))
    else $error("zero filter time does not pass the sample");
endmodule

// >>> design/frs_top.sv
/*
  Frequency reference select: AHB-Lite register file, analog curve, up/down
  adjustment and multi-segment speed selection.
  Assumes ADC words and terminals are asynchronous; hclk at 100 MHz.
*/
`timescale 1ns/100ps
module frs_top
  import frs_pkg::*;
#(
  parameter int MS_CYCLES_P = frs_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog samples
  input wire logic [11:0] analog_input_one,
  input wire logic [11:0] analog_input_two,
  // Control terminals
  input wire logic term_run,
  input wire logic term_reverse,
  input wire logic term_up,
  input wire logic term_down,
  input wire logic [3:0] term_speed,
  // Frequency reference
  output logic [16:0] freq_out,
  output logic dir_reverse,
  output logic run_active,
  output logic [3:0] seg_index,
  output logic [1:0] ramp_sel
);
  import frs_pkg::*;
  // Registers
  logic [3:0] chan_sel_q;
  logic [9:0] filter_time_q;
  logic [13:0] high_freq_q, low_freq_q;
  logic [3:0] bias_q;
  logic ud_mem_q, ud_unit_q;
  logic [7:0] ud_mult_q;
  logic [2:0] mode_q;
  logic [15:0] seg_dir_q;
  logic [31:0] seg_ramp_q;
  logic [13:0] seg_freq_q [16];
  logic [15:0] seg_time_q [16];
  // Bus
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [7:0] a_addr;
  // Synchronisers
  logic [11:0] ain1_s1_q, ain1_s2_q, ain2_s1_q, ain2_s2_q;
  logic [7:0] term_s1_q, term_s2_q;
  logic run_in, rev_in, up_in, down_in, up_prev_q, down_prev_q;
  logic [3:0] spd_in;
  // Timebase
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [9:0] ms_in_sec_q;
  logic sec_tick;
  logic seg_restart;
  // Analog curve
  logic [11:0] filtered;
  logic [11:0] span_zero;
  logic [13:0] recip;
  logic [12:0] t_raw;
  logic [26:0] t_prod;
  logic [12:0] t_norm;
  logic signed [15:0] s_low, s_high, s_diff, f_d1;
  logic signed [29:0] slope;
  logic [16:0] analog_mag;
  logic analog_neg;
  // Up/down and segments
  logic signed [18:0] ud_q, ud_step, ud_next, sum;
  logic run_prev_q;
  logic [3:0] seg_q;
  logic [15:0] seg_elapsed_q;
  logic [3:0] sel_idx;
  logic sel_any, run_req;
  logic [16:0] freq_d;
  logic dir_d;

  // AHB-Lite: zero wait states, always OKAY; reads answered in the data phase
  assign a_addr = {haddr[7:2], 2'b00};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
      begin
        wr_addr_q <= a_addr;
        rdata_q <= 32'h0000_0000;
        if (!hwrite)
        begin
          if (a_addr == OFS_CHANNEL)
            rdata_q <= {28'h0, chan_sel_q};
          else if (a_addr == OFS_FILTER)
            rdata_q <= {22'h0, filter_time_q};
          else if (a_addr == OFS_HIGH_FREQ)
            rdata_q <= {18'h0, high_freq_q};
          else if (a_addr == OFS_LOW_FREQ)
            rdata_q <= {18'h0, low_freq_q};
          else if (a_addr == OFS_BIAS)
            rdata_q <= {28'h0, bias_q};
          else if (a_addr == OFS_UPDOWN)
            rdata_q <= {16'h0, ud_mult_q, 6'h0, ud_unit_q, ud_mem_q};
          else if (a_addr == OFS_SEG_MODE)
            rdata_q <= {29'h0, mode_q};
          else if (a_addr == OFS_SEG_DIR)
            rdata_q <= {16'h0, seg_dir_q};
          else if (a_addr == OFS_SEG_RAMP)
            rdata_q <= seg_ramp_q;
          else if (a_addr == OFS_STATUS)
            rdata_q <= {4'h0, seg_index, 2'h0, run_active, dir_reverse, 3'h0, freq_out};
          else if (a_addr == OFS_UD_VALUE)
            rdata_q <= 32'(ud_q);
          else if (a_addr >= OFS_SEG_FREQ && a_addr < OFS_SEG_TIME)
            rdata_q <= {18'h0, seg_freq_q[a_addr[5:2]]};
          else if (a_addr >= OFS_SEG_TIME && a_addr < 8'hc0)
            rdata_q <= {16'h0, seg_time_q[a_addr[5:2]]};
        end
      end
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Register writes; filter time, frequencies, multiplier and mode saturate to the legal limits, channel is stored as written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chan_sel_q <= RST_CHANNEL;
      filter_time_q <= RST_FILTER;
      high_freq_q <= RST_HIGH_FREQ;
      low_freq_q <= RST_LOW_FREQ;
      bias_q <= 4'h0;
      ud_mem_q <= 1'b0;
      ud_unit_q <= 1'b0;
      ud_mult_q <= RST_MULT;
      mode_q <= RST_SEG_MODE;
      seg_dir_q <= 16'h0000;
      seg_ramp_q <= 32'h0000_0000;
      for (int i = 0; i < 16; i++)
      begin
        seg_freq_q[i] <= 14'h0000;
        seg_time_q[i] <= 16'h0000;
      end
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == OFS_CHANNEL)
        chan_sel_q <= hwdata[3:0];
      else if (wr_addr_q == OFS_FILTER)
        filter_time_q <= (hwdata[15:0] > 16'd1000) ? 10'd1000 : hwdata[9:0];
      else if (wr_addr_q == OFS_HIGH_FREQ)
        high_freq_q <= (hwdata[15:0] > 16'(MAX_FREQ_D1)) ? MAX_FREQ_D1 : hwdata[13:0];
      else if (wr_addr_q == OFS_LOW_FREQ)
        low_freq_q <= (hwdata[15:0] > 16'(MAX_FREQ_D1)) ? MAX_FREQ_D1 : hwdata[13:0];
      else if (wr_addr_q == OFS_BIAS)
        bias_q <= hwdata[3:0];
      else if (wr_addr_q == OFS_UPDOWN)
      begin
        ud_mem_q <= hwdata[UD_MEM_BIT];
        ud_unit_q <= hwdata[UD_UNIT_BIT];
        if (hwdata[UD_MULT_LSB+:8] == 8'h00)
          ud_mult_q <= 8'h01;
        else if (hwdata[UD_MULT_LSB+:8] > 8'd250)
          ud_mult_q <= 8'd250;
        else
          ud_mult_q <= hwdata[UD_MULT_LSB+:8];
      end
      else if (wr_addr_q == OFS_SEG_MODE)
        mode_q <= (hwdata[2:0] > 3'd5) ? 3'd5 : hwdata[2:0];
      else if (wr_addr_q == OFS_SEG_DIR)
        seg_dir_q <= hwdata[15:0];
      else if (wr_addr_q == OFS_SEG_RAMP)
        seg_ramp_q <= hwdata;
      else if (wr_addr_q >= OFS_SEG_FREQ && wr_addr_q < OFS_SEG_TIME)
        seg_freq_q[wr_addr_q[5:2]] <= (hwdata[15:0] > 16'(MAX_FREQ_D1)) ?
          MAX_FREQ_D1 : hwdata[13:0];
      else if (wr_addr_q >= OFS_SEG_TIME && wr_addr_q < 8'hc0)
        seg_time_q[wr_addr_q[5:2]] <= hwdata[15:0];
    end
  end

  // Two-flop synchronisers; ADC words are assumed to change slowly, so tearing is rare
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ain1_s1_q <= 12'h000;
      ain1_s2_q <= 12'h000;
      ain2_s1_q <= 12'h000;
      ain2_s2_q <= 12'h000;
      term_s1_q <= 8'h00;
      term_s2_q <= 8'h00;
    end
    else
    begin
      ain1_s1_q <= analog_input_one;
      ain1_s2_q <= ain1_s1_q;
      ain2_s1_q <= analog_input_two;
      ain2_s2_q <= ain2_s1_q;
      term_s1_q <= {term_speed, term_down, term_up, term_reverse, term_run};
      term_s2_q <= term_s1_q;
    end
  end
  assign {spd_in, down_in, up_in, rev_in, run_in} = term_s2_q;

  // Millisecond and second ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_cnt_q <= 32'h0000_0000;
      ms_in_sec_q <= 10'h000;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (sec_tick || seg_restart)
        ms_in_sec_q <= 10'h000;
      else if (ms_tick)
        ms_in_sec_q <= ms_in_sec_q + 10'h001;
    end
  end
  assign ms_tick = ms_cnt_q == 32'(MS_CYCLES_P - 1);
  assign sec_tick = ms_tick && ms_in_sec_q == MS_PER_SEC - 10'h001;

  frs_lowpass #(.WIDTH(12), .FRAC(10)) u_lowpass (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(ms_tick),
    .time_ms(filter_time_q),
    .sample(bias_q[BIAS_CHAN2_BIT] ? ain2_s2_q : ain1_s2_q),
    .filtered(filtered)
  );

  // Analog curve: normalise to 0..4096, then interpolate between signed ends
  always_comb
  begin
    if (chan_sel_q >= 4'd10)
    begin
      span_zero = (chan_sel_q == 4'd11) ? ZERO_5V : ZERO_10V;
      recip = (chan_sel_q == 4'd11) ? RECIP_LZ_5V : RECIP_LZ_10V;
    end
    else
    begin
      span_zero = 12'h000;
      recip = (chan_sel_q == 4'd1) ? RECIP_5V : RECIP_10V;
    end
    t_raw = (filtered > span_zero) ? 13'(filtered - span_zero) : 13'h0000;
    t_prod = 27'(t_raw) * 27'(recip);
    t_norm = (t_prod[26:12] > 15'(T_FULL)) ? T_FULL : t_prod[24:12];
    s_high = bias_q[BIAS_HIGH_BIT] ? -$signed({2'b00, high_freq_q}) :
      $signed({2'b00, high_freq_q});
    s_low = bias_q[BIAS_LOW_BIT] ? -$signed({2'b00, low_freq_q}) :
      $signed({2'b00, low_freq_q});
    s_diff = s_high - s_low;
    slope = 30'(s_diff) * 30'($signed({1'b0, t_norm}));
    f_d1 = s_low + 16'(slope >>> 12);
    analog_neg = f_d1 < 0;
    analog_mag = analog_neg ? 17'(-f_d1) * 17'd10 : 17'(f_d1) * 17'd10;
    if (analog_neg && !bias_q[BIAS_NEGREV_BIT])
    begin
      analog_mag = 17'h00000;
      analog_neg = 1'b0;
    end
  end

  // Up/down offset, in 0.01 Hz
  always_comb
  begin
    ud_step = 19'(ud_mult_q) * (ud_unit_q ? 19'sd10 : 19'sd1);
    ud_next = ud_q;
    if (up_in && !up_prev_q)
      ud_next = ud_q + ud_step;
    else if (down_in && !down_prev_q)
      ud_next = ud_q - ud_step;
    if (ud_next > $signed({2'b00, MAX_FREQ_D2}))
      ud_next = $signed({2'b00, MAX_FREQ_D2});
    else if (ud_next < -$signed({2'b00, MAX_FREQ_D2}))
      ud_next = -$signed({2'b00, MAX_FREQ_D2});
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ud_q <= 19'sd0;
      up_prev_q <= 1'b0;
      down_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
    end
    else
    begin
      up_prev_q <= up_in;
      down_prev_q <= down_in;
      run_prev_q <= run_req;
      if (run_prev_q && !run_req && !ud_mem_q)
        ud_q <= 19'sd0;
      else
        ud_q <= ud_next;
    end
  end

  // Segment selection
  always_comb
  begin
    sel_idx = 4'h0;
    sel_any = 1'b0;
    case (frs_mode_type'(mode_q))
      FRS_INT16:
        sel_idx = seg_q;
      FRS_EXT4, FRS_EXT4_AUTO:
      begin
        sel_any = |spd_in[2:0];
        if (spd_in[0])
          sel_idx = 4'h1;
        else if (spd_in[1])
          sel_idx = 4'h2;
        else if (spd_in[2])
          sel_idx = 4'h3;
      end
      FRS_EXT16, FRS_EXT16_AUTO:
      begin
        sel_any = |spd_in;
        sel_idx = spd_in;
      end
      default:
        sel_idx = 4'h0;
    endcase
    run_req = run_in;
    if (mode_q == FRS_EXT4_AUTO || mode_q == FRS_EXT16_AUTO)
      run_req = run_in || sel_any;
    sum = 19'(analog_mag) + ud_q;
    if (sel_idx != 4'h0)
      freq_d = 17'(seg_freq_q[sel_idx]) * 17'd10;
    else if (sum < 0)
      freq_d = 17'h00000;
    else if (sum > $signed({2'b00, MAX_FREQ_D2}))
      freq_d = MAX_FREQ_D2;
    else
      freq_d = 17'(sum);
    if (mode_q == FRS_INT16)
      dir_d = seg_q[3] ? seg_dir_q[8 + seg_q[2:0]] : seg_dir_q[seg_q[2:0]];
    else if (sel_idx == 4'h0)
      dir_d = analog_neg ^ rev_in;
    else
      dir_d = rev_in;
  end

  // Second count restarts with each segment, else the first second of a segment is short
  assign seg_restart = mode_q != FRS_INT16 || !run_req || seg_time_q[seg_q] == 16'h0000 ||
    (sec_tick && seg_elapsed_q + 16'h0001 >= seg_time_q[seg_q]);

  // Internal sequencer: a zero timer skips its segment
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seg_q <= 4'h0;
      seg_elapsed_q <= 16'h0000;
    end
    else if (mode_q != FRS_INT16 || !run_req)
    begin
      seg_q <= 4'h0;
      seg_elapsed_q <= 16'h0000;
    end
    else if (seg_time_q[seg_q] == 16'h0000 ||
      (sec_tick && seg_elapsed_q + 16'h0001 >= seg_time_q[seg_q]))
    begin
      seg_q <= seg_q + 4'h1;
      seg_elapsed_q <= 16'h0000;
    end
    else if (sec_tick)
      seg_elapsed_q <= seg_elapsed_q + 16'h0001;
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_out <= 17'h00000;
      dir_reverse <= 1'b0;
      run_active <= 1'b0;
      seg_index <= 4'h0;
      ramp_sel <= 2'h0;
    end
    else
    begin
      freq_out <= freq_d;
      dir_reverse <= dir_d;
      run_active <= run_req;
      seg_index <= sel_idx;
      if (mode_q == FRS_INT16)
        ramp_sel <= seg_ramp_q[{seg_q, 1'b0}+:2];
      else
        ramp_sel <= 2'h0;
    end
  end

  a_span_ten: assert property (@(posedge hclk) disable iff (!hresetn)
    chan_sel_q == 4'd0 |-> span_zero == 12'h000 && recip == RECIP_10V)
    else $error("zero-to-ten span not selected");
  a_live_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    chan_sel_q == 4'd10 && filtered <= ZERO_10V |-> t_norm == 13'h0000)
    else $error("live zero offset not applied");
  a_freq_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    freq_out <= MAX_FREQ_D2)
    else $error("frequency above limit");
  a_no_reverse: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == FRS_NORMAL && !bias_q[BIAS_NEGREV_BIT] && !rev_in |=> !dir_reverse)
    else $error("reverse without negative-bias enable");
  a_ext_invert: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == FRS_NORMAL && analog_neg && rev_in |=> !dir_reverse)
    else $error("reverse terminal did not invert curve");
  a_updown_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    run_prev_q && !run_req && !ud_mem_q |=> ud_q == 19'sd0)
    else $error("up/down value kept without memory");
  a_step_size: assert property (@(posedge hclk) disable iff (!hresetn)
    up_in && !up_prev_q && !(run_prev_q && !run_req) && ud_q < 19'sd90000
    |=> ud_q == $past(ud_q) + $past(ud_step))
    else $error("up step size wrong");
  a_auto_run: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == FRS_EXT4_AUTO && spd_in[0] |=> run_active && seg_index == 4'h1)
    else $error("auto run not started by segment select");
  a_int_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == FRS_INT16 && seg_q == 4'h0 |=> dir_reverse == $past(seg_dir_q[0]))
    else $error("internal direction not taken from segment bits");
  c_negative_curve: cover property (@(posedge hclk) disable iff (!hresetn)
    analog_neg && bias_q[BIAS_NEGREV_BIT]);
  c_seg_advance: cover property (@(posedge hclk) disable iff (!hresetn)
    mode_q == FRS_INT16 && seg_q == 4'h1);
  c_ud_retained: cover property (@(posedge hclk) disable iff (!hresetn)
    run_prev_q && !run_req && ud_mem_q && ud_q != 19'sd0);
endmodule

// >>> verification/frs_far_side.sv
/*
  Far side model: analog sources and control terminals of the drive.
  Assumes the bench calls its tasks; pins change just after a rising edge.
*/
`timescale 1ns/100ps
module frs_far_side (
  // Clock
  input wire logic hclk,
  // Analog samples
  output logic [11:0] analog_input_one,
  output logic [11:0] analog_input_two,
  // Terminals
  output logic term_run,
  output logic term_reverse,
  output logic term_up,
  output logic term_down,
  output logic [3:0] term_speed
);
  // Retention across power loss is the operator's job, kept on with memory
  localparam logic RETAIN_ON_POWER_OFF = 1'b1;
  initial
  begin
    analog_input_one = 12'h000;
    analog_input_two = 12'h000;
    term_run = 1'b0;
    term_reverse = 1'b0;
    term_up = 1'b0;
    term_down = 1'b0;
    term_speed = 4'h0;
  end
  task automatic set_analog(input logic [11:0] one, input logic [11:0] two);
    @(posedge hclk);
    analog_input_one <= one;
    analog_input_two <= two;
  endtask
  task automatic set_terms(input logic run, input logic rev, input logic [3:0] spd);
    @(posedge hclk);
    term_run <= run;
    term_reverse <= rev;
    term_speed <= spd;
  endtask
  // Held 3 cycles and released 3, so the synchroniser sees one clean edge
  task automatic step(input logic up);
    @(posedge hclk);
    term_up <= up;
    term_down <= !up;
    repeat (3) @(posedge hclk);
    term_up <= 1'b0;
    term_down <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// >>> verification/tb_top.sv
/*
  Self-checking bench for the frequency reference select block.
  Assumes a zero-wait AHB-Lite slave and a shortened millisecond of 20 cycles.
*/
`timescale 1ns/100ps
module tb_top;
  import frs_pkg::*;
  localparam int MSC = 20;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, t_run, t_rev, t_up, t_down, dir_reverse, run_active;
  logic [11:0] a_one, a_two;
  logic [3:0] t_spd, seg_index;
  logic [16:0] freq_out;
  logic [1:0] ramp_sel;
  // Mode [11:9], run [8], terminals [7:4], expected segment [3:0]
  logic [11:0] tbl [6] = '{12'h522, 12'h543, 12'h7bb, 12'h811, 12'ha66, 12'h150};
  int fails = 0;
  int compares = 0;
  int n;
  always #5 hclk = ~hclk;
  frs_far_side far (.hclk(hclk), .analog_input_one(a_one), .analog_input_two(a_two),
    .term_run(t_run), .term_reverse(t_rev), .term_up(t_up), .term_down(t_down),
    .term_speed(t_spd));
  frs_top #(.MS_CYCLES_P(MSC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_input_one(a_one), .analog_input_two(a_two), .term_run(t_run),
    .term_reverse(t_rev), .term_up(t_up), .term_down(t_down), .term_speed(t_spd),
    .freq_out(freq_out), .dir_reverse(dir_reverse), .run_active(run_active),
    .seg_index(seg_index), .ramp_sel(ramp_sel));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    logic ok;
    begin
      ok = (got + tol >= exp) && (got <= exp + tol);
      compares++;
      if (ok !== 1'b1)
      begin
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, 32'h0);
  endtask
  // Outputs are looked at mid-cycle, clear of the edge that updates them
  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
    @(negedge hclk);
  endtask
  // The filter moves only on a millisecond tick, so wait one tick plus the pipeline
  task automatic fq(input logic [31:0] exp, input logic [31:0] tol);
    wt(MSC + 4);
    chk({15'h0, freq_out}, exp, tol);
  endtask
  task automatic t_reset;
    rdc(OFS_CHANNEL, 32'h0);
    rdc(OFS_FILTER, 32'h14);
    rdc(OFS_HIGH_FREQ, 32'h1f4);
    rdc(OFS_LOW_FREQ, 32'h0);
    rdc(OFS_UPDOWN, 32'h100);
    rdc(OFS_SEG_MODE, 32'h2);
    rdc(8'h3c, 32'h0);
    wr(OFS_SEG_MODE, 32'h7);
    rdc(OFS_SEG_MODE, 32'h5);
    wr(OFS_UPDOWN, 32'h0);
    rdc(OFS_UPDOWN, 32'h100);
    wr(OFS_HIGH_FREQ, 32'h3fff);
    rdc(OFS_HIGH_FREQ, 32'h2710);
  endtask
  task automatic t_curve;
    wr(OFS_FILTER, 32'h0);
    wr(OFS_SEG_MODE, 32'h0);
    wr(OFS_HIGH_FREQ, 32'h190);
    far.set_terms(1'b1, 1'b0, 4'h0);
    wr(OFS_CHANNEL, 32'h0);
    far.set_analog(12'd2048, 12'h0);
    fq(2000, 20);
    wr(OFS_CHANNEL, 32'h1);
    far.set_analog(12'd1024, 12'h0);
    fq(2000, 20);
    wr(OFS_CHANNEL, 32'ha);
    far.set_analog(12'd819, 12'h0);
    fq(0, 20);
    far.set_analog(12'd2457, 12'h0);
    fq(2000, 20);
    wr(OFS_CHANNEL, 32'h0);
    wr(OFS_LOW_FREQ, 32'h64);
    wr(OFS_BIAS, 32'h2);
    far.set_analog(12'd819, 12'h0);
    fq(0, 20);
    far.set_analog(12'd4095, 12'h0);
    fq(4000, 20);
    far.set_analog(12'd0, 12'h0);
    fq(0, 0);
    chk({31'h0, dir_reverse}, 32'h0, 32'h0);
    wr(OFS_BIAS, 32'h6);
    fq(1000, 0);
    chk({31'h0, dir_reverse}, 32'h1, 32'h0);
    far.set_terms(1'b1, 1'b1, 4'h0);
    wt(8);
    chk({31'h0, dir_reverse}, 32'h0, 32'h0);
    far.set_terms(1'b1, 1'b0, 4'h0);
    wr(OFS_LOW_FREQ, 32'h0);
    wr(OFS_BIAS, 32'h8);
    far.set_analog(12'd0, 12'd2048);
    fq(2000, 20);
    wr(OFS_BIAS, 32'h0);
  endtask
  task automatic t_filter;
    far.set_analog(12'd0, 12'd0);
    fq(0, 0);
    wr(OFS_FILTER, 32'h14);
    far.set_analog(12'd4095, 12'd0);
    wt(2 * MSC);
    chk({15'h0, freq_out}, 32'h0, 32'd1000);
    wt(400 * MSC);
    chk({15'h0, freq_out}, 32'd4000, 32'd100);
    wr(OFS_FILTER, 32'h0);
    far.set_analog(12'd0, 12'd0);
  endtask
  task automatic t_updown;
    wr(OFS_UPDOWN, 32'h302);
    far.step(1'b1);
    fq(30, 0);
    far.step(1'b1);
    fq(60, 0);
    far.step(1'b0);
    fq(30, 0);
    wr(OFS_UPDOWN, 32'hfa00);
    far.step(1'b1);
    fq(280, 0);
    far.set_terms(1'b0, 1'b0, 4'h0);
    far.set_terms(1'b1, 1'b0, 4'h0);
    fq(0, 0);
    wr(OFS_UPDOWN, 32'hfa01);
    far.step(1'b1);
    far.set_terms(1'b0, 1'b0, 4'h0);
    far.set_terms(1'b1, 1'b0, 4'h0);
    fq(250, 0);
    rdc(OFS_UD_VALUE, 32'd250);
    far.step(1'b0);
    far.step(1'b0);
    fq(0, 0);
    wr(OFS_UPDOWN, 32'h100);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_SEG_MODE, {29'h0, tbl[i][11:9]});
      far.set_terms(tbl[i][8], 1'b0, tbl[i][7:4]);
      wt(8);
      chk({31'h0, run_active}, 32'h1, 32'h0);
      chk({28'h0, seg_index}, {28'h0, tbl[i][3:0]}, 32'h0);
    end
    wr(OFS_SEG_MODE, 32'h2);
    far.set_terms(1'b0, 1'b0, 4'h1);
    wt(8);
    chk({31'h0, run_active}, 32'h0, 32'h0);
  endtask
  task automatic t_internal;
    wr(OFS_SEG_TIME, 32'h1);
    wr(OFS_SEG_TIME + 8'h08, 32'h1);
    wr(OFS_SEG_FREQ + 8'h08, 32'h7b);
    wr(OFS_SEG_DIR, 32'h4);
    wr(OFS_SEG_RAMP, 32'h31);
    far.set_analog(12'd2048, 12'd0);
    far.set_terms(1'b1, 1'b1, 4'hf);
    wr(OFS_SEG_MODE, 32'h1);
    n = 0;
    wt(MSC + 4);
    chk({28'h0, seg_index}, 32'h0, 32'h0);
    chk({31'h0, dir_reverse}, 32'h0, 32'h0);
    chk({30'h0, ramp_sel}, 32'h1, 32'h0);
    chk({15'h0, freq_out}, 32'd2000, 32'd20);
    while (seg_index !== 4'h2 && n < 25000)
    begin
      @(negedge hclk);
      n++;
    end
    chk(n, 32'd20000, 32'd100);
    fq(1230, 0);
    chk({28'h0, seg_index}, 32'h2, 32'h0);
    chk({31'h0, dir_reverse}, 32'h1, 32'h0);
    chk({30'h0, ramp_sel}, 32'h3, 32'h0);
  endtask
  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_curve();
    t_filter();
    t_updown();
    t_modes();
    t_internal();
    close_out();
  end
  // Whole run needs about 29000 cycles
  initial
  begin
    repeat (90000) @(posedge hclk);
    fails++;
    close_out();
  end
endmodule
